// [verilog/gpiop_top.sv]
// port a, port d with parallel slave mode, port e strobes
// assumes apb master on clock; pins and comparator results synchronous
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module gpiop_top
  import gpiop_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire gpiop_pkg::gpiop_apb_req_t apb_req,
  output var gpiop_pkg::gpiop_apb_rsp_t apb_rsp,
  input wire logic [1:0] cmp_result,
  input wire logic [5:0] port_a_in,
  output logic [5:0] port_a_out,
  output logic [5:0] port_a_oe,
  input wire logic [7:0] port_d_in,
  output logic [7:0] port_d_out,
  output logic [7:0] port_d_oe,
  input wire logic [2:0] port_e_in,
  output logic [2:0] port_e_out,
  output logic [2:0] port_e_oe
);
  // all state of the block
  typedef struct packed {
    logic [5:0] a_lat;
    logic [5:0] a_dir;
    logic [7:0] d_lat;
    logic [7:0] d_dir;
    logic [2:0] e_lat;
    logic [7:0] e_ctl;
    logic [2:0] cmp_mode;
    logic [7:0] ref_ctl;
    logic [5:0] a_out;
    logic [5:0] a_oe;
    logic [7:0] d_out;
    logic [7:0] d_oe;
    logic [2:0] e_out;
    logic [2:0] e_oe;
  } gpiop_state_t;
  gpiop_state_t q, d;

  // bus side
  logic hit;
  logic wr_go;
  logic rd_go;
  logic [7:0] rdata;
  logic [9:0] idx;
  logic [7:0] wmask;
  logic [7:0] wbyte;
  // slave port strobes
  logic psp_on;
  logic rd_sel;
  logic wr_sel;
  logic rd_end;
  logic wr_end;
  // port a helpers
  logic [5:0] a_analog;
  logic [5:0] a_read;

  assign idx = reg_index(apb_req.paddr);
  assign wbyte = apb_req.pwdata[7:0];
  assign psp_on = q.e_ctl[E_PSP];

  // apb slave front end
  gpiop_apb u_apb
  (
    .clock(clock),
    .rst_n(rst_n),
    .req(apb_req),
    .hit(hit),
    .rdata(rdata),
    .rsp(apb_rsp),
    .wr_go(wr_go),
    .rd_go(rd_go)
  );

  // slave port strobes come from the port e pins
  gpiop_strobe u_strobe
  (
    .clock(clock),
    .rst_n(rst_n),
    .enable(psp_on),
    .rd_n(port_e_in[0]),
    .wr_n(port_e_in[1]),
    .cs_n(port_e_in[2]),
    .rd_sel(rd_sel),
    .wr_sel(wr_sel),
    .rd_end(rd_end),
    .wr_end(wr_end)
  );

  // second byte lane, when written, picks the bits to modify
  always_comb
  begin
    if (apb_req.pstrb[1])
      wmask = apb_req.pwdata[15:8];
    else
      wmask = 8'hff;
  end

  // pins taken as analog comparator inputs for each mode
  always_comb
  begin
    unique case (q.cmp_mode)
      CM_OFF: a_analog = 6'h00;
      CM_PINOUT: a_analog = 6'h03;
      default: a_analog = 6'h0f; // reset mode: inputs grounded
    endcase
  end

  // analog pins read as zero, the rest give pin levels
  assign a_read = port_a_in & ~a_analog;

  // address decode and read mux
  always_comb
  begin
    hit = (apb_req.paddr[1:0] == 2'b00);
    rdata = 8'h00;
    unique case (idx)
      IDX_PORT_A: rdata = {2'b00, a_read};
      // slave mode reads the buffer, otherwise the pins
      IDX_PORT_D: rdata = psp_on ? q.d_lat : port_d_in;
      // strobe pins read as inputs in slave mode
      IDX_PORT_E: rdata = {5'h00, port_e_in};
      IDX_CMP_CTL: rdata = {cmp_result, 3'b000, q.cmp_mode};
      IDX_DIR_A: rdata = {2'b00, q.a_dir};
      IDX_DIR_D: rdata = q.d_dir;
      // bit 3 reads zero
      IDX_CTL_E: rdata = {q.e_ctl[7:4], 1'b0, q.e_ctl[2:0]};
      IDX_REF_CTL: rdata = q.ref_ctl;
      default: hit = 1'b0; // unmapped index answers with pslverr
    endcase
  end

  // next state: registers, slave port, pin drivers
  always_comb
  begin
    logic [7:0] merged;
    logic [7:0] ctl;
    merged = 8'h00;
    ctl = 8'h00;
    d = q;

    // software writes; merge is taken over the sampled pins, over the buffer for port d in slave mode
    if (wr_go)
    begin
      unique case (idx)
        IDX_PORT_A:
        begin
          merged = rmw({2'b00, a_read}, wbyte, wmask);
          d.a_lat = merged[5:0];
        end
        IDX_PORT_D:
        begin
          merged = rmw(psp_on ? q.d_lat : port_d_in, wbyte, wmask);
          d.d_lat = merged;
          if (psp_on)
            d.e_ctl[E_OBF] = 1'b1; // byte waits for the host
        end
        IDX_PORT_E:
        begin
          merged = rmw({5'h00, port_e_in}, wbyte, wmask);
          d.e_lat = merged[2:0];
        end
        IDX_CMP_CTL:
          d.cmp_mode = wbyte[2:0];
        IDX_DIR_A:
          d.a_dir = wbyte[5:0];
        IDX_DIR_D:
          d.d_dir = wbyte;
        IDX_CTL_E:
        begin
          // full flags are read only, overrun clears on zero
          ctl = rmw(q.e_ctl, wbyte, wmask);
          d.e_ctl[E_PSP] = ctl[E_PSP];
          d.e_ctl[2:0] = ctl[2:0];
          if (!ctl[E_INPUT_OVERRUN_FLAG])
            d.e_ctl[E_INPUT_OVERRUN_FLAG] = 1'b0;
        end
        IDX_REF_CTL:
          d.ref_ctl = wbyte;
        default:
          d.ref_ctl = q.ref_ctl; // unmapped: nothing stored
      endcase
    end

    // software read of the buffer empties it
    if (rd_go && idx == IDX_PORT_D && psp_on)
      d.e_ctl[E_IBF] = 1'b0;

    // host write: track the byte while the strobe is low
    if (wr_sel)
      d.d_lat = port_d_in;
    // end of host write: full, overrun if still full; set wins
    if (wr_end)
    begin
      if (q.e_ctl[E_IBF])
        d.e_ctl[E_INPUT_OVERRUN_FLAG] = 1'b1;
      d.e_ctl[E_IBF] = 1'b1;
    end
    // end of host read: buffer taken by the host; a new byte in the same cycle wins
    if (rd_end && !(wr_go && idx == IDX_PORT_D && psp_on))
      d.e_ctl[E_OBF] = 1'b0;

    // port a drivers: direction one floats the pin
    d.a_out = q.a_lat;
    d.a_oe = ~q.a_dir;
    // comparator results replace latch on bits 3 and 4
    if (q.cmp_mode == CM_PINOUT)
    begin
      d.a_out[3] = cmp_result[0];
      d.a_out[4] = cmp_result[1];
    end
    // bit 4 only pulls low
    d.a_oe[4] = ~q.a_dir[4] & ~d.a_out[4];
    d.a_out[4] = 1'b0;
    // reference takes bit 2; its drive is outside this logic
    if (q.ref_ctl[REF_OE])
      d.a_oe[2] = 1'b0;

    // port d drivers
    if (psp_on)
    begin
      d.d_out = q.d_lat;
      d.d_oe = {8{rd_sel}};
    end
    else
    begin
      d.d_out = q.d_lat;
      d.d_oe = ~q.d_dir;
    end

    // port e drivers; strobes are inputs in slave mode
    d.e_out = q.e_lat;
    if (psp_on)
      d.e_oe = 3'b000;
    else
      d.e_oe = ~q.e_ctl[2:0];
  end

  // state register with reset values
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q.a_lat <= RST_LAT[5:0];
      q.a_dir <= RST_DIR_A;
      q.d_lat <= RST_LAT;
      q.d_dir <= RST_DIR_D;
      q.e_lat <= RST_LAT[2:0];
      q.e_ctl <= RST_CTL_E;
      q.cmp_mode <= RST_CMP;
      q.ref_ctl <= RST_REF;
      q.a_out <= 6'h00;
      q.a_oe <= 6'h00;
      q.d_out <= 8'h00;
      q.d_oe <= 8'h00;
      q.e_out <= 3'b000;
      q.e_oe <= 3'b000;
    end
    else
    begin
      q <= d;
    end
  end

  // pin outputs straight from the state register
  assign port_a_out = q.a_out;
  assign port_a_oe = q.a_oe;
  assign port_d_out = q.d_out;
  assign port_d_oe = q.d_oe;
  assign port_e_out = q.e_out;
  assign port_e_oe = q.e_oe;
endmodule
`default_nettype wire

// [common/gpiop_pkg.sv]
// constants, carrier structs and helpers for the port block
// assumes one 100 MHz clock and an apb master with 32-bit data
package gpiop_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_PORT_A = 10'h005;
  localparam logic [9:0] IDX_PORT_D = 10'h008;
  localparam logic [9:0] IDX_PORT_E = 10'h009;
  localparam logic [9:0] IDX_CMP_CTL = 10'h01f;
  localparam logic [9:0] IDX_DIR_A = 10'h085;
  localparam logic [9:0] IDX_DIR_D = 10'h088;
  localparam logic [9:0] IDX_CTL_E = 10'h089;
  localparam logic [9:0] IDX_REF_CTL = 10'h09f;
  // fields of port_e_control_direction
  localparam int E_IBF = 7;
  localparam int E_OBF = 6;
  localparam int E_INPUT_OVERRUN_FLAG = 5;
  localparam int E_PSP = 4;
  // field of reference_control: reference drives port_a_bit2
  localparam int REF_OE = 6;
  // comparator mode codes
  localparam logic [2:0] CM_OFF = 3'h7;
  localparam logic [2:0] CM_PINOUT = 3'h6;
  // values after reset
  localparam logic [5:0] RST_DIR_A = 6'h3f;
  localparam logic [7:0] RST_DIR_D = 8'hff;
  localparam logic [7:0] RST_CTL_E = 8'h07;
  localparam logic [2:0] RST_CMP = 3'h0;
  localparam logic [7:0] RST_REF = 8'h00;
  localparam logic [7:0] RST_LAT = 8'h00;
  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } gpiop_apb_req_t;
  // apb answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } gpiop_apb_rsp_t;
  // word index of an aligned byte address
  function automatic logic [9:0] reg_index(input logic [11:0] a);
    return a[11:2];
  endfunction
  // merge written bits over sampled pin levels
  function automatic logic [7:0] rmw(input logic [7:0] pins,
    input logic [7:0] wdata, input logic [7:0] mask);
    return (pins & ~mask) | (wdata & mask);
  endfunction
endpackage

// [verilog/gpiop_apb.sv]
// apb slave front end: one wait state, error on unmapped index
// assumes the top decodes the index and supplies read data
`timescale 1ns/1ns
`default_nettype none
module gpiop_apb
  import gpiop_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire gpiop_pkg::gpiop_apb_req_t req,
  input wire logic hit,
  input wire logic [7:0] rdata,
  output var gpiop_pkg::gpiop_apb_rsp_t rsp,
  output logic wr_go,
  output logic rd_go
);
  // all state of the slave
  gpiop_apb_rsp_t q, d;

  // raise pready after the first access cycle, capture data there
  always_comb
  begin
    d = q;
    d.pready = req.psel & req.penable & ~q.pready;
    if (d.pready)
    begin
      d.pslverr = ~hit;
      d.prdata = (hit & ~req.pwrite) ? {24'h00_0000, rdata} : 32'h0000_0000;
    end
  end

  // state register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  // commit strobes at the edge where pready is seen high
  assign wr_go = req.psel & req.penable & q.pready & req.pwrite & ~q.pslverr;
  assign rd_go = req.psel & req.penable & q.pready & ~req.pwrite & ~q.pslverr;
  assign rsp = q;
endmodule
`default_nettype wire

// [verilog/gpiop_strobe.sv]
// decodes the slave port strobes and marks their ends
// assumes strobe pins are synchronous to clock
`timescale 1ns/1ns
`default_nettype none
module gpiop_strobe
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic cs_n,
  output logic rd_sel,
  output logic wr_sel,
  output logic rd_end,
  output logic wr_end
);
  // previous selected strobe levels
  typedef struct packed {
    logic rd;
    logic wr;
  } gpiop_stb_t;
  gpiop_stb_t q, d;

  // strobes count only while selected and in slave mode
  always_comb
  begin
    d.rd = enable & ~cs_n & ~rd_n;
    d.wr = enable & ~cs_n & ~wr_n;
  end

  // state register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign rd_sel = d.rd;
  assign wr_sel = d.wr;
  // strobe ends when it leaves its active level
  assign rd_end = q.rd & ~d.rd;
  assign wr_end = q.wr & ~d.wr;
endmodule
`default_nettype wire

// [dv/gpiop_props.sv]
// checker: apb timing and pad rules of the port block
// sees only the top ports; bound to every gpiop_top below
`timescale 1ns/1ns
`default_nettype none
module gpiop_props
  import gpiop_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire gpiop_pkg::gpiop_apb_req_t apb_req,
  input wire gpiop_pkg::gpiop_apb_rsp_t apb_rsp,
  input wire logic [5:0] port_a_out,
  input wire logic [5:0] port_a_oe,
  input wire logic [2:0] port_e_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // at most one wait state
  property p_wait;
    apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready;
  endproperty
  a_wait: assert property (p_wait) else $error("no answer after wait");
  // answer is one cycle long
  property p_pulse;
    apb_rsp.pready |=> !apb_rsp.pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready held");
  // answer only inside an access
  property p_req;
    apb_rsp.pready |-> apb_req.psel && apb_req.penable;
  endproperty
  a_req: assert property (p_req) else $error("ready outside access");
  // misaligned access is refused
  property p_err;
    apb_req.psel && apb_req.penable && !apb_rsp.pready && apb_req.paddr[1:0] != 2'b00 |=> apb_rsp.pslverr;
  endproperty
  a_err: assert property (p_err) else $error("misaligned not refused");
  // registers are eight bits wide
  property p_hi;
    apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h00_0000;
  endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  // read data moves only with an answer
  property p_hold;
    $changed(apb_rsp.prdata) |-> apb_rsp.pready;
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  // bit4 can only pull low
  property p_od;
    port_a_oe[4] |-> !port_a_out[4];
  endproperty
  a_od: assert property (p_od) else $error("bit4 drives high");
  // port a enables of bits 0 to 3 move only after a register access
  property p_aoe;
    $changed(port_a_oe[3:0]) |-> $past(apb_rsp.pready) || $past(apb_rsp.pready, 2) || $past(apb_rsp.pready, 3);
  endproperty
  a_aoe: assert property (p_aoe) else $error("port a enable moved");
  // port e drivers move only after a register access
  property p_eoe;
    $changed(port_e_oe) |-> $past(apb_rsp.pready) || $past(apb_rsp.pready, 2) || $past(apb_rsp.pready, 3);
  endproperty
  a_eoe: assert property (p_eoe) else $error("port e enable moved");
endmodule
bind gpiop_top gpiop_props u_props (.clock(clock), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .port_a_out(port_a_out), .port_a_oe(port_a_oe), .port_e_oe(port_e_oe));
`default_nettype wire

// [dv/gpiop_host.sv]
// host processor model driving the slave port strobes and data
// tasks are called by the bench right after a rising edge
`timescale 1ns/1ns
`default_nettype none
module gpiop_host
(
  input wire logic clock,
  input wire logic [7:0] pd,
  output logic rd_n,
  output logic wr_n,
  output logic cs_n,
  output logic hoe,
  output logic [7:0] hd
);
  // idle: strobes high, data released
  initial
  begin
    rd_n = 1'b1;
    wr_n = 1'b1;
    cs_n = 1'b1;
    hoe = 1'b0;
    hd = 8'h00;
  end
  // store one byte; s selects the device
  task wr(input logic [7:0] b, input logic s);
    @(posedge clock);
    cs_n <= ~s;
    wr_n <= 1'b0;
    hd <= b;
    hoe <= 1'b1;
    repeat (3) @(posedge clock);
    wr_n <= 1'b1;
    cs_n <= 1'b1;
    @(posedge clock);
    hoe <= 1'b0;
    // hd takes the inverse of the last byte, but released lines show the bench level
    hd <= ~b;
    @(posedge clock);
  endtask
  // fetch one byte while the read strobe is low
  task rd(input logic s, output logic [7:0] v);
    @(posedge clock);
    cs_n <= ~s;
    rd_n <= 1'b0;
    repeat (3) @(posedge clock);
    v = pd;
    rd_n <= 1'b1;
    cs_n <= 1'b1;
    @(posedge clock);
  endtask
endmodule
`default_nettype wire

// [dv/port_io_with_parallel_slave_tb_top.sv]
// bench: apb master, pad levels, host model, read-data queue
// expects the checker bound to gpiop_top
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; $display("CHECK FAILED %0t mismatch %h", $time, a); end end
module port_io_with_parallel_slave_tb_top;
  import gpiop_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  gpiop_apb_req_t req = '0;
  gpiop_apb_rsp_t rsp;
  logic [1:0] cmp = 2'b00;
  logic [5:0] a_ext = 6'h00;
  logic [7:0] d_ext = 8'h00;
  logic [5:0] a_out, a_oe, e6;
  logic [7:0] d_out, d_oe, hd, m, x, v;
  logic [2:0] e_out, e_oe;
  logic rd_n, wr_n, cs_n, hoe;
  logic [32:0] ex;
  logic [32:0] q[$];
  logic [31:0] s = 32'h0000_0056;
  logic [31:0] r;
  int failures = 0;
  int samples_checked = 0;
  int cyc = 0;
  // pad levels from every driver
  wire logic [5:0] pa = (a_oe & a_out) | (~a_oe & a_ext);
  wire logic [7:0] pd = (d_oe & d_out) | (~d_oe & (hoe ? hd : d_ext));
  wire logic [2:0] pe = (e_oe & e_out) | (~e_oe & {cs_n, wr_n, rd_n});
  always #5 clock = ~clock;
  gpiop_top dut (.clock(clock), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp), .cmp_result(cmp),
    .port_a_in(pa), .port_a_out(a_out), .port_a_oe(a_oe), .port_d_in(pd), .port_d_out(d_out),
    .port_d_oe(d_oe), .port_e_in(pe), .port_e_out(e_out), .port_e_oe(e_oe));
  gpiop_host hst (.clock(clock), .pd(pd), .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n), .hoe(hoe), .hd(hd));
  function logic [31:0] xs();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  // one apb transfer; reads note their expected answer
  task apb(input logic w, input logic [11:0] a, input logic [15:0] d, input logic [32:0] e);
    @(posedge clock);
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= {16'h0000, d};
    req.pstrb <= {2'b00, |d[15:8], 1'b1};
    if (!w) q.push_back(e);
    @(posedge clock);
    req.penable <= 1'b1;
    @(posedge clock);
    while (rsp.pready !== 1'b1) @(posedge clock);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task wr(input logic [9:0] i, input logic [15:0] d);
    apb(1'b1, {i, 2'b00}, d, 33'h0);
  endtask
  task rd(input logic [9:0] i, input logic [7:0] e);
    apb(1'b0, {i, 2'b00}, 16'h0000, {25'h0, e});
  endtask
  task results();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // read answers against the oldest note
  always @(posedge clock)
  begin
    if (rsp.pready === 1'b1 && req.psel === 1'b1 && req.pwrite === 1'b0)
    begin
      ex = q.pop_front();
      if (ex[32]) `CHK(rsp.pslverr, 1'b1)
      else `CHK({rsp.pslverr, rsp.prdata}, ex)
    end
  end
  // hang guard
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      failures++;
      results();
    end
  end
  initial
  begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    r = xs();
    a_ext <= r[5:0];
    d_ext <= r[15:8];
    m = r[23:16] | 8'h01;
    x = r[31:24];
    rd(IDX_DIR_D, RST_DIR_D);
    rd(IDX_CTL_E, RST_CTL_E);
    rd(IDX_DIR_A, {2'b00, RST_DIR_A});
    rd(IDX_PORT_A, {2'b00, r[5:4], 4'h0});
    apb(1'b0, 12'hffc, 16'h0000, {1'b1, 32'h0000_0000});
    apb(1'b0, 12'h022, 16'h0000, {1'b1, 32'h0000_0000});
    wr(IDX_CMP_CTL, {13'h0000, CM_OFF});
    wr(IDX_PORT_A, {m, x});
    e6 = (r[5:0] & ~m[5:0]) | (x[5:0] & m[5:0]);
    wr(IDX_DIR_A, 16'h0000);
    rd(IDX_PORT_A, {2'b00, e6[5], e6[4] & r[4], e6[3:0]});
    wr(IDX_CMP_CTL, {13'h0000, CM_PINOUT});
    for (int i = 0; i < 2; i++)
    begin
      cmp <= {2{i[0]}};
      // second pass also puts the reference on bit2
      if (i == 1) wr(IDX_REF_CTL, 16'h0040);
      repeat (2) @(posedge clock);
      rd(IDX_PORT_A, {2'b00, e6[5], i[0] & r[4], i[0], i[0] ? r[2] : e6[2], 2'b00});
    end
    wr(IDX_PORT_D, {8'h00, x});
    wr(IDX_DIR_D, {8'h00, m});
    rd(IDX_PORT_D, (x & ~m) | (r[15:8] & m));
    wr(IDX_CTL_E, 16'h0017);
    hst.wr(x, 1'b1);
    rd(IDX_CTL_E, 8'h97);
    `CHK(e_oe, 3'b000)
    hst.wr(m, 1'b1);
    rd(IDX_CTL_E, 8'hb7);
    rd(IDX_PORT_D, m);
    rd(IDX_CTL_E, 8'h37);
    wr(IDX_CTL_E, 16'h0017);
    hst.wr(~m, 1'b0);
    rd(IDX_PORT_D, m);
    rd(IDX_CTL_E, 8'h17);
    wr(IDX_PORT_D, {8'h00, x});
    rd(IDX_CTL_E, 8'h57);
    hst.rd(1'b1, v);
    `CHK(v, x)
    repeat (3) @(posedge clock);
    `CHK(d_oe, 8'h00)
    rd(IDX_CTL_E, 8'h17);
    d_ext <= ~x;
    hst.rd(1'b0, v);
    `CHK(v, ~x)
    results();
  end
endmodule
`default_nettype wire
